// ===== hdl/cprfs_defines.vh
// constants for the register, flag and stack core
`ifndef CPRFS_DEFINES_VH
`define CPRFS_DEFINES_VH
// ****************************************
// avalon register offsets (byte addresses)
// ****************************************
`define CPRFS_OFF_CTRL      8'h00
`define CPRFS_OFF_OPERAND   8'h04
`define CPRFS_OFF_RESULT    8'h08
`define CPRFS_OFF_FLAGS     8'h0C
`define CPRFS_OFF_IPTR      8'h10
`define CPRFS_OFF_STACK     8'h14
`define CPRFS_OFF_REG       8'h18
`define CPRFS_OFF_PAIR      8'h1C
`define CPRFS_OFF_BUS       8'h20
`define CPRFS_OFF_STATUS    8'h24
// ****************************************
// flag bit positions
// ****************************************
`define CPRFS_FLAG_SIGN     7
`define CPRFS_FLAG_ZERO     6
`define CPRFS_FLAG_HALF     4
`define CPRFS_FLAG_PARITY   2
`define CPRFS_FLAG_CARRY    0
`define CPRFS_FLAG_USED     8'hD5
`define CPRFS_FLAG_FILL     8'h02
// ****************************************
// reset values
// ****************************************
`define CPRFS_RST_FLAGS     8'h02
`define CPRFS_RST_WORD      16'h0000
// ****************************************
// alu operation codes (ctrl[3:0])
// ****************************************
`define CPRFS_OP_ADD        4'h0
`define CPRFS_OP_ADC        4'h1
`define CPRFS_OP_SUB        4'h2
`define CPRFS_OP_SBB        4'h3
`define CPRFS_OP_AND        4'h4
`define CPRFS_OP_XOR        4'h5
`define CPRFS_OP_OR         4'h6
`define CPRFS_OP_CMP        4'h7
`define CPRFS_OP_RLC        4'h8
`define CPRFS_OP_RRC        4'h9
`define CPRFS_OP_INR        4'hA
`define CPRFS_OP_DCR        4'hB
// ****************************************
// ctrl command codes (ctrl[7:4])
// ****************************************
`define CPRFS_CMD_ALU       4'h1
`define CPRFS_CMD_ALU_BUS   4'h2
`define CPRFS_CMD_PUSH      4'h3
`define CPRFS_CMD_POP       4'h4
`define CPRFS_CMD_INX       4'h5
`define CPRFS_CMD_DCX       4'h6
`define CPRFS_CMD_MEMRD     4'h7
`define CPRFS_CMD_MEMWR     4'h8
`define CPRFS_CMD_IORD      4'h9
`define CPRFS_CMD_IOWR      4'hA
// ****************************************
// pointer step sizes
// ****************************************
`define CPRFS_STACK_STEP    16'h0002
`define CPRFS_PAIR_STEP     16'h0001
`endif

// ===== hdl/cprfs_alu.v
// arithmetic, logic and rotate unit with flag generation
`timescale 1ns/1ps
`include "cprfs_defines.vh"
module cprfs_alu (
  input  wire [3:0] op,
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire [7:0] flags_in,
  output reg  [7:0] result,
  output reg  [7:0] flags_out
);
  reg  [8:0] sum;
  reg  [4:0] low;
  reg        cin;
  reg        cy;
  reg        hc;
  reg        keep_cy;

  always @* begin
    cin     = flags_in[`CPRFS_FLAG_CARRY];
    sum     = 9'h000;
    low     = 5'h00;
    cy      = 1'b0;
    hc      = 1'b0;
    keep_cy = 1'b0;
    result  = a;
    case (op)
      `CPRFS_OP_ADD, `CPRFS_OP_ADC: begin
        sum    = {1'b0, a} + {1'b0, b} + {8'h00, (op == `CPRFS_OP_ADC) & cin};
        low    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == `CPRFS_OP_ADC) & cin};
        result = sum[7:0];
        cy     = sum[8];
        hc     = low[4];
      end
      // subtraction as add of the complement; carry then reads as a borrow
      `CPRFS_OP_SUB, `CPRFS_OP_SBB, `CPRFS_OP_CMP: begin
        sum    = {1'b0, a} + {1'b0, ~b} + {8'h00, ~((op == `CPRFS_OP_SBB) & cin)};
        low    = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~((op == `CPRFS_OP_SBB) & cin)};
        result = (op == `CPRFS_OP_CMP) ? a : sum[7:0];
        cy     = ~sum[8];
        hc     = low[4];
      end
      `CPRFS_OP_AND: begin
        result = a & b;
        hc     = a[3] | b[3];
      end
      `CPRFS_OP_XOR: result = a ^ b;
      `CPRFS_OP_OR:  result = a | b;
      `CPRFS_OP_RLC: begin
        result = {a[6:0], a[7]};
        cy     = a[7];
      end
      `CPRFS_OP_RRC: begin
        result = {a[0], a[7:1]};
        cy     = a[0];
      end
      // increment and decrement leave carry alone but still set zero
      `CPRFS_OP_INR: begin
        result  = a + 8'h01;
        hc      = (a[3:0] == 4'hF);
        keep_cy = 1'b1;
      end
      `CPRFS_OP_DCR: begin
        result  = a - 8'h01;
        hc      = (a[3:0] != 4'h0);
        keep_cy = 1'b1;
      end
      default: result = a;
    endcase
    flags_out = `CPRFS_FLAG_FILL;
    flags_out[`CPRFS_FLAG_SIGN]   = (op == `CPRFS_OP_CMP) ? sum[7] : result[7];
    flags_out[`CPRFS_FLAG_ZERO]   = (op == `CPRFS_OP_CMP) ? (sum[7:0] == 8'h00) : (result == 8'h00);
    flags_out[`CPRFS_FLAG_HALF]   = hc;
    flags_out[`CPRFS_FLAG_PARITY] = (op == `CPRFS_OP_CMP) ? ~^sum[7:0] : ~^result;
    flags_out[`CPRFS_FLAG_CARRY]  = keep_cy ? cin : cy;
  end
endmodule

// ===== hdl/cprfs_regfile.v
// eight addressable 8-bit registers with registered read port
`timescale 1ns/1ps
module cprfs_regfile #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  input  wire                     clock,
  input  wire                     rst_n,
  input  wire                     wr_en,
  input  wire [2:0]               wr_addr,
  input  wire [WIDTH-1:0]         wr_data,
  input  wire [2:0]               rd_addr,
  output reg  [WIDTH-1:0]         rd_data,
  output wire [DEPTH*WIDTH-1:0]   all_q
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  integer i;
  genvar g;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
      rd_data <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
    end
  end

  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : flat
      assign all_q[g*WIDTH +: WIDTH] = mem_q[g];
    end
  endgenerate
endmodule

// ===== hdl/cprfs_core.v
// register, flag and stack core with avalon-mm access and multiplexed external bus
`timescale 1ns/1ps
`include "cprfs_defines.vh"
module cprfs_core (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [7:0]  muxed_low_bus_out,
  output reg         muxed_low_bus_oe_n,
  input  wire [7:0]  muxed_low_bus_in,
  output reg  [7:0]  high_address_lines,
  output reg         addr_latch_strobe,
  output reg         io_select,
  output reg         read_strobe_n,
  output reg         write_strobe_n
);
  // ****************************************
  // bus cycle states
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_ADDR = 2'b01;
  localparam ST_DATA = 2'b10;
  localparam ST_DONE = 2'b11;

  // ****************************************
  // state
  // ****************************************
  reg  [7:0]  result_q;
  reg  [7:0]  condition_flags_q;
  reg  [15:0] instruction_pointer_q;
  reg  [15:0] stack_top_pointer_q;
  reg  [7:0]  operand_q;
  reg  [7:0]  bus_data_q;
  reg  [7:0]  alu_bus_q;
  reg  [1:0]  bus_st_q;
  reg  [3:0]  bus_cmd_q;
  reg  [15:0] bus_addr_q;
  reg  [7:0]  bus_wdata_q;
  reg  [7:0]  low_sync1_q;
  reg  [7:0]  low_sync2_q;
  reg  [1:0]  rd_wait_q;
  reg         ack_q;
  reg  [2:0]  sel_q;
  reg         rf_we;
  reg  [2:0]  rf_waddr;
  reg  [7:0]  rf_wdata;
  wire [7:0]  rf_rdata;
  wire [63:0] rf_all;
  wire [7:0]  alu_result;
  wire [7:0]  alu_flags;

  wire        access   = avs_read | avs_write;
  wire        wr_fire  = avs_write & ~avs_waitrequest;
  wire        busy     = (bus_st_q != ST_IDLE);
  wire [3:0]  cmd      = avs_writedata[7:4];
  wire [3:0]  op       = avs_writedata[3:0];
  wire [1:0]  pair_sel = avs_writedata[9:8];
  wire        cmd_go   = wr_fire & (avs_address == `CPRFS_OFF_CTRL) & avs_byteenable[0];

  // one wait state so register file read data can be registered; bus commands hold off while busy
  assign avs_waitrequest = access & (~ack_q | (avs_write & (avs_address == `CPRFS_OFF_CTRL) & busy));

  // pair index 0..2 = second, third, memory pointer; 3 = stack
  function [15:0] pair_of;
    input [1:0]  sel;
    input [63:0] regs;
    input [15:0] sp;
    begin
      case (sel)
        2'd0:    pair_of = {regs[7:0],   regs[15:8]};
        2'd1:    pair_of = {regs[23:16], regs[31:24]};
        2'd2:    pair_of = {regs[39:32], regs[47:40]};
        default: pair_of = sp;
      endcase
    end
  endfunction

  cprfs_regfile #(
    .WIDTH (8),
    .DEPTH (8)
  ) u_rf (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (rf_we),
    .wr_addr (rf_waddr),
    .wr_data (rf_wdata),
    .rd_addr (sel_q),
    .rd_data (rf_rdata),
    .all_q   (rf_all)
  );

  cprfs_alu u_alu (
    .op        (op),
    .a         (result_q),
    .b         (operand_q),
    .flags_in  (condition_flags_q),
    .result    (alu_result),
    .flags_out (alu_flags)
  );

  // ****************************************
  // register file write port: software and pair steps
  // ****************************************
  wire [15:0] pair_now  = pair_of(pair_sel, rf_all, stack_top_pointer_q);
  wire [15:0] pair_next = (cmd == `CPRFS_CMD_INX) ? pair_now + `CPRFS_PAIR_STEP : pair_now - `CPRFS_PAIR_STEP;
  reg         hi_pend_q;
  reg  [2:0]  hi_addr_q;
  reg  [7:0]  hi_data_q;

  always @* begin
    rf_we    = 1'b0;
    rf_waddr = 3'd0;
    rf_wdata = 8'h00;
    if (hi_pend_q) begin
      rf_we    = 1'b1;
      rf_waddr = hi_addr_q;
      rf_wdata = hi_data_q;
    end else if (wr_fire & (avs_address == `CPRFS_OFF_REG)) begin
      rf_we    = 1'b1;
      rf_waddr = avs_writedata[10:8];
      rf_wdata = avs_writedata[7:0];
    end else if (cmd_go & ((cmd == `CPRFS_CMD_INX) | (cmd == `CPRFS_CMD_DCX)) & (pair_sel != 2'd3)) begin
      rf_we    = 1'b1;
      rf_waddr = {pair_sel, 1'b1};
      rf_wdata = pair_next[7:0];
    end
  end

  // ****************************************
  // programmer state and register interface
  // ****************************************
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q              <= 8'h00;
      condition_flags_q     <= `CPRFS_RST_FLAGS;
      instruction_pointer_q <= `CPRFS_RST_WORD;
      stack_top_pointer_q   <= `CPRFS_RST_WORD;
      operand_q             <= 8'h00;
      alu_bus_q             <= 8'h00;
      ack_q                 <= 1'b0;
      sel_q                 <= 3'd0;
      hi_pend_q             <= 1'b0;
      hi_addr_q             <= 3'd0;
      hi_data_q             <= 8'h00;
      avs_readdata          <= 32'h0000_0000;
    end else begin
      ack_q     <= access & ~ack_q;
      hi_pend_q <= 1'b0;
      if (access & ~ack_q & avs_read) begin
        case (avs_address)
          `CPRFS_OFF_RESULT:  avs_readdata <= {24'h00_0000, result_q};
          `CPRFS_OFF_FLAGS:   avs_readdata <= {24'h00_0000, condition_flags_q};
          `CPRFS_OFF_IPTR:    avs_readdata <= {16'h0000, instruction_pointer_q};
          `CPRFS_OFF_STACK:   avs_readdata <= {16'h0000, stack_top_pointer_q};
          `CPRFS_OFF_OPERAND: avs_readdata <= {24'h00_0000, operand_q};
          `CPRFS_OFF_PAIR:    avs_readdata <= {16'h0000, pair_of(avs_writedata[1:0], rf_all, stack_top_pointer_q)};
          `CPRFS_OFF_BUS:     avs_readdata <= {16'h0000, alu_bus_q, bus_data_q};
          `CPRFS_OFF_STATUS:  avs_readdata <= {31'h0000_0000, busy};
          `CPRFS_OFF_REG:     avs_readdata <= {24'h00_0000, rf_rdata};
          default:            avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (wr_fire) begin
        case (avs_address)
          `CPRFS_OFF_RESULT:  result_q <= avs_writedata[7:0];
          `CPRFS_OFF_OPERAND: operand_q <= avs_writedata[7:0];
          // only the five flag positions take the write
          `CPRFS_OFF_FLAGS:   condition_flags_q <= (avs_writedata[7:0] & `CPRFS_FLAG_USED) | `CPRFS_FLAG_FILL;
          `CPRFS_OFF_IPTR:    instruction_pointer_q <= avs_writedata[15:0];
          `CPRFS_OFF_STACK:   stack_top_pointer_q <= avs_writedata[15:0];
          `CPRFS_OFF_REG:     sel_q <= avs_writedata[10:8];
          default:            sel_q <= sel_q;
        endcase
      end
      if (cmd_go) begin
        case (cmd)
          `CPRFS_CMD_ALU: begin
            if (op != `CPRFS_OP_CMP) begin
              result_q <= alu_result;
            end
            condition_flags_q <= alu_flags;
          end
          `CPRFS_CMD_ALU_BUS: begin
            alu_bus_q         <= alu_result;
            condition_flags_q <= alu_flags;
          end
          `CPRFS_CMD_PUSH: stack_top_pointer_q <= stack_top_pointer_q - `CPRFS_STACK_STEP;
          `CPRFS_CMD_POP:  stack_top_pointer_q <= stack_top_pointer_q + `CPRFS_STACK_STEP;
          `CPRFS_CMD_INX, `CPRFS_CMD_DCX: begin
            if (pair_sel == 2'd3) begin
              stack_top_pointer_q <= pair_next;
            end else begin
              hi_pend_q <= 1'b1;
              hi_addr_q <= {pair_sel, 1'b0};
              hi_data_q <= pair_next[15:8];
            end
          end
          default: result_q <= result_q;
        endcase
      end
    end
  end

  // ****************************************
  // external multiplexed bus cycle
  // ****************************************
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_st_q           <= ST_IDLE;
      bus_cmd_q          <= 4'h0;
      bus_addr_q         <= 16'h0000;
      bus_wdata_q        <= 8'h00;
      bus_data_q         <= 8'h00;
      low_sync1_q        <= 8'h00;
      low_sync2_q        <= 8'h00;
      rd_wait_q          <= 2'd0;
      muxed_low_bus_out  <= 8'h00;
      muxed_low_bus_oe_n <= 1'b1;
      high_address_lines <= 8'h00;
      addr_latch_strobe  <= 1'b0;
      io_select          <= 1'b0;
      read_strobe_n      <= 1'b1;
      write_strobe_n     <= 1'b1;
    end else begin
      low_sync1_q <= muxed_low_bus_in;
      low_sync2_q <= low_sync1_q;
      case (bus_st_q)
        ST_IDLE: begin
          if (cmd_go & (cmd >= `CPRFS_CMD_MEMRD) & (cmd <= `CPRFS_CMD_IOWR)) begin
            bus_cmd_q   <= cmd;
            bus_wdata_q <= result_q;
            // memory through the pointer pair (or selected pair); io uses an 8-bit port number
            if ((cmd == `CPRFS_CMD_IORD) | (cmd == `CPRFS_CMD_IOWR)) begin
              bus_addr_q <= {avs_writedata[23:16], avs_writedata[23:16]};
            end else begin
              bus_addr_q <= pair_of((pair_sel == 2'd3) ? 2'd2 : pair_sel, rf_all, stack_top_pointer_q);
            end
            bus_st_q <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          muxed_low_bus_out  <= bus_addr_q[7:0];
          muxed_low_bus_oe_n <= 1'b0;
          high_address_lines <= bus_addr_q[15:8];
          io_select          <= (bus_cmd_q == `CPRFS_CMD_IORD) | (bus_cmd_q == `CPRFS_CMD_IOWR);
          addr_latch_strobe  <= 1'b1;
          bus_st_q           <= ST_DATA;
        end
        ST_DATA: begin
          addr_latch_strobe <= 1'b0;
          if ((bus_cmd_q == `CPRFS_CMD_MEMWR) | (bus_cmd_q == `CPRFS_CMD_IOWR)) begin
            muxed_low_bus_out <= bus_wdata_q;
            write_strobe_n    <= 1'b0;
          end else begin
            muxed_low_bus_oe_n <= 1'b1;
            read_strobe_n      <= 1'b0;
          end
          bus_st_q <= ST_DONE;
        end
        ST_DONE: begin
          // read strobe stays low until the pin has passed both sync stages
          if (~read_strobe_n & (rd_wait_q != 2'd2)) begin
            rd_wait_q <= rd_wait_q + 2'd1;
          end else begin
            if (~read_strobe_n) begin
              bus_data_q <= low_sync2_q;
            end
            rd_wait_q          <= 2'd0;
            read_strobe_n      <= 1'b1;
            write_strobe_n     <= 1'b1;
            muxed_low_bus_oe_n <= 1'b1;
            bus_st_q           <= ST_IDLE;
          end
        end
        default: bus_st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== verif/cprfs_core_properties.sv
// port-level assertions for the register, flag and stack core
`timescale 1ns/1ps
`include "cprfs_defines.vh"
module cprfs_props (
  input wire        clock,
  input wire        rst_n,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_waitrequest,
  input wire [31:0] avs_readdata,
  input wire        muxed_low_bus_oe_n,
  input wire [7:0]  high_address_lines,
  input wire        addr_latch_strobe,
  input wire        io_select,
  input wire        read_strobe_n,
  input wire        write_strobe_n
);
  // ****************************************
  // external bus and flag byte
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ale_pulse: assert property (addr_latch_strobe |=> !addr_latch_strobe)
    else $error("address strobe longer than one cycle");
  a_addr_on_bus: assert property (addr_latch_strobe |-> !muxed_low_bus_oe_n)
    else $error("low bus not driven during address phase");
  a_read_bus_free: assert property (!read_strobe_n |-> muxed_low_bus_oe_n)
    else $error("low bus still driven during read");
  a_write_data_out: assert property (!write_strobe_n |-> !muxed_low_bus_oe_n)
    else $error("low bus not driven during write");
  a_strobe_after_ale: assert property (($fell(read_strobe_n) || $fell(write_strobe_n)) |-> $past(addr_latch_strobe))
    else $error("data strobe without address phase");
  a_addr_held: assert property (addr_latch_strobe |=> $stable(high_address_lines) && $stable(io_select))
    else $error("upper address or io select moved in cycle");
  a_strobe_single: assert property (!write_strobe_n |=> write_strobe_n)
    else $error("write strobe longer than one cycle");
  a_read_strobe_len: assert property ($fell(read_strobe_n) |=> !read_strobe_n ##1 !read_strobe_n ##1 read_strobe_n)
    else $error("read strobe not three cycles long");
  a_flag_fill: assert property (avs_read && !avs_waitrequest && avs_address == `CPRFS_OFF_FLAGS |-> (avs_readdata & 32'hFFFF_FF2A) == 32'h0000_0002)
    else $error("unused flag positions not constant");
endmodule
bind cprfs_core cprfs_props i_props (.clock, .rst_n, .avs_address, .avs_read, .avs_waitrequest, .avs_readdata,
  .muxed_low_bus_oe_n, .high_address_lines, .addr_latch_strobe, .io_select, .read_strobe_n, .write_strobe_n);

// ===== verif/cprfs_ext_dev.sv
// memory and io port devices on the far side of the multiplexed bus
`timescale 1ns/1ps
module cprfs_ext_dev (
  input  wire       clock,
  input  wire [7:0] muxed_low_bus_out,
  input  wire       muxed_low_bus_oe_n,
  input  wire [7:0] high_address_lines,
  input  wire       addr_latch_strobe,
  input  wire       io_select,
  input  wire       read_strobe_n,
  input  wire       write_strobe_n,
  output wire [7:0] muxed_low_bus_in
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  io  [0:255];
  logic [15:0] addr = 16'h0000;
  logic        io_cyc = 1'b0;
  logic [1:0]  hold = 2'd0;
  logic [7:0]  last = 8'h00;
  wire         drv = !read_strobe_n || hold != 2'd0;
  wire  [7:0]  rdv = io_cyc ? io[addr[7:0]] : mem[addr];
  // ****************************************
  // wire level: no pull, so a released bus toggles every cycle
  // ****************************************
  assign muxed_low_bus_in = !muxed_low_bus_oe_n ? muxed_low_bus_out : drv ? rdv : ~last;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8];
    end
    for (int i = 0; i < 256; i++) begin
      io[i] = ~i[7:0];
    end
  end
  always @(posedge clock) begin
    last <= muxed_low_bus_in;
    hold <= !read_strobe_n ? 2'd2 : (hold == 2'd0 ? 2'd0 : hold - 2'd1);
    if (addr_latch_strobe) begin
      addr   <= {high_address_lines, muxed_low_bus_out};
      io_cyc <= io_select;
    end
    if (!write_strobe_n && io_cyc) begin
      io[addr[7:0]] <= muxed_low_bus_out;
    end
    if (!write_strobe_n && !io_cyc) begin
      mem[addr] <= muxed_low_bus_out;
    end
  end
endmodule

// ===== verif/tb_cprfs_core.sv
// self-checking bench for the register, flag and stack core
`timescale 1ns/1ps
`include "cprfs_defines.vh"
module tb_cprfs_core;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  wire         avs_waitrequest;
  wire  [7:0]  lb_out;
  wire  [7:0]  lb_in;
  wire  [7:0]  hi;
  wire         oe_n, ale, iosel, rd_n, wr_n;
  int          mismatches = 0;
  int          check_count = 0;
  always #25 clock = ~clock;
  cprfs_core i_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .muxed_low_bus_out(lb_out), .muxed_low_bus_oe_n(oe_n),
    .muxed_low_bus_in(lb_in), .high_address_lines(hi), .addr_latch_strobe(ale), .io_select(iosel),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n));
  cprfs_ext_dev i_ext (.clock(clock), .muxed_low_bus_out(lb_out), .muxed_low_bus_oe_n(oe_n),
    .high_address_lines(hi), .addr_latch_strobe(ale), .io_select(iosel), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .muxed_low_bus_in(lb_in));
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic acc(input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= rd;
    avs_write     <= !rd;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b0, a, d);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    acc(1'b1, a, d);
    chk(q, e);
  endtask
  task automatic setr(input logic [2:0] i, input logic [7:0] v);
    wr(`CPRFS_OFF_REG, {21'h00_0000, i, v});
  endtask
  // polling busy keeps later accesses from racing an external cycle
  task automatic cmd(input logic [3:0] c, input logic [3:0] o, input logic [1:0] p, input logic [7:0] port);
    wr(`CPRFS_OFF_CTRL, {8'h00, port, 6'h00, p, c, o});
    do begin
      acc(1'b1, `CPRFS_OFF_STATUS, 32'h0000_0000);
    end while (q[0] !== 1'b0);
  endtask
  task automatic alu(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] r, input logic [7:0] f, input logic [7:0] m);
    wr(`CPRFS_OFF_RESULT, {24'h00_0000, a});
    wr(`CPRFS_OFF_OPERAND, {24'h00_0000, b});
    cmd(`CPRFS_CMD_ALU, o, 2'd0, 8'h00);
    rdc(`CPRFS_OFF_RESULT, 32'h0000_0000, {24'h00_0000, r});
    acc(1'b1, `CPRFS_OFF_FLAGS, 32'h0000_0000);
    chk({24'h00_0000, q[7:0] & m}, {24'h00_0000, f & m});
  endtask
  task automatic bus_rd(input logic [7:0] e);
    acc(1'b1, `CPRFS_OFF_BUS, 32'h0000_0000);
    chk({24'h00_0000, q[7:0]}, {24'h00_0000, e});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    conclude();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rdc(`CPRFS_OFF_FLAGS, 32'h0000_0000, 32'h0000_0002);
    rdc(`CPRFS_OFF_IPTR, 32'h0000_0000, 32'h0000_0000);
    wr(`CPRFS_OFF_FLAGS, 32'h0000_00FF);
    rdc(`CPRFS_OFF_FLAGS, 32'h0000_0000, 32'h0000_00D7);
    wr(`CPRFS_OFF_FLAGS, 32'h0000_0000);
    rdc(`CPRFS_OFF_FLAGS, 32'h0000_0000, 32'h0000_0002);
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0000_0000, 32'h0000_0000);
    wr(`CPRFS_OFF_RESULT, 32'hFFFF_FFFF);
    rdc(`CPRFS_OFF_RESULT, 32'h0000_0000, 32'h0000_00FF);
    alu(`CPRFS_OP_ADD, 8'hAE, 8'h74, 8'h22, 8'h17, 8'hFF);
    alu(`CPRFS_OP_ADD, 8'hA7, 8'h59, 8'h00, 8'h57, 8'hFF);
    alu(`CPRFS_OP_SUB, 8'h10, 8'h20, 8'hF0, 8'h87, 8'hEF);
    alu(`CPRFS_OP_INR, 8'hFF, 8'h00, 8'h00, 8'h57, 8'hFF);
    alu(`CPRFS_OP_DCR, 8'h01, 8'h00, 8'h00, 8'h47, 8'hEF);
    alu(`CPRFS_OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h92, 8'hFF);
    alu(`CPRFS_OP_XOR, 8'h5A, 8'h0F, 8'h55, 8'h04, 8'hC4);
    alu(`CPRFS_OP_AND, 8'hF0, 8'h3C, 8'h30, 8'h04, 8'hC4);
    alu(`CPRFS_OP_OR, 8'h00, 8'h00, 8'h00, 8'h44, 8'hC4);
    alu(`CPRFS_OP_RLC, 8'h81, 8'h00, 8'h03, 8'h01, 8'h01);
    wr(`CPRFS_OFF_RESULT, 32'h0000_0011);
    wr(`CPRFS_OFF_OPERAND, 32'h0000_0022);
    cmd(`CPRFS_CMD_ALU_BUS, `CPRFS_OP_ADD, 2'd0, 8'h00);
    rdc(`CPRFS_OFF_RESULT, 32'h0000_0000, 32'h0000_0011);
    acc(1'b1, `CPRFS_OFF_BUS, 32'h0000_0000);
    chk({24'h00_0000, q[15:8]}, 32'h0000_0033);
    for (int i = 0; i < 8; i++) begin
      setr(i[2:0], 8'hA0 + i[7:0]);
      rdc(`CPRFS_OFF_REG, 32'h0000_0000, {24'h00_0000, 8'hA0 + i[7:0]});
    end
    for (int i = 0; i < 3; i++) begin
      rdc(`CPRFS_OFF_PAIR, {30'h0000_0000, i[1:0]}, {16'h0000, 8'hA0 + {i[6:0], 1'b0}, 8'hA1 + {i[6:0], 1'b0}});
    end
    setr(3'd4, 8'h00);
    setr(3'd5, 8'hFF);
    cmd(`CPRFS_CMD_INX, 4'h0, 2'd2, 8'h00);
    rdc(`CPRFS_OFF_PAIR, 32'h0000_0002, 32'h0000_0100);
    cmd(`CPRFS_CMD_DCX, 4'h0, 2'd2, 8'h00);
    rdc(`CPRFS_OFF_PAIR, 32'h0000_0002, 32'h0000_00FF);
    wr(`CPRFS_OFF_STACK, 32'h0000_1000);
    cmd(`CPRFS_CMD_PUSH, 4'h0, 2'd3, 8'h00);
    rdc(`CPRFS_OFF_STACK, 32'h0000_0000, 32'h0000_0FFE);
    cmd(`CPRFS_CMD_PUSH, 4'h0, 2'd3, 8'h00);
    cmd(`CPRFS_CMD_POP, 4'h0, 2'd3, 8'h00);
    rdc(`CPRFS_OFF_STACK, 32'h0000_0000, 32'h0000_0FFE);
    wr(`CPRFS_OFF_STACK, 32'h0000_0000);
    cmd(`CPRFS_CMD_PUSH, 4'h0, 2'd3, 8'h00);
    rdc(`CPRFS_OFF_STACK, 32'h0000_0000, 32'h0000_FFFE);
    wr(`CPRFS_OFF_IPTR, 32'h0000_BEEF);
    rdc(`CPRFS_OFF_IPTR, 32'h0000_0000, 32'h0000_BEEF);
    setr(3'd4, 8'h12);
    setr(3'd5, 8'h34);
    cmd(`CPRFS_CMD_MEMRD, 4'h0, 2'd2, 8'h00);
    bus_rd(8'h26);
    wr(`CPRFS_OFF_RESULT, 32'h0000_005A);
    cmd(`CPRFS_CMD_MEMWR, 4'h0, 2'd2, 8'h00);
    chk({24'h00_0000, i_ext.mem[16'h1234]}, 32'h0000_005A);
    cmd(`CPRFS_CMD_MEMRD, 4'h0, 2'd2, 8'h00);
    bus_rd(8'h5A);
    wr(`CPRFS_OFF_RESULT, 32'h0000_00C3);
    cmd(`CPRFS_CMD_IOWR, 4'h0, 2'd0, 8'h34);
    chk({24'h00_0000, i_ext.io[8'h34]}, 32'h0000_00C3);
    chk({24'h00_0000, i_ext.mem[16'h0034]}, 32'h0000_0034);
    cmd(`CPRFS_CMD_IORD, 4'h0, 2'd0, 8'h77);
    bus_rd(8'h88);
    cmd(`CPRFS_CMD_IORD, 4'h0, 2'd0, 8'h34);
    bus_rd(8'hC3);
    conclude();
  end
endmodule
